// File: hw/scp_axis.sv
/*
 * S-curve speed profile for one axis with an APB register slave, profile
 * tick base and step pulse output.
 * Assumes an APB master on pclk, synchronous sync_speed_* inputs, and a
 * motor driver taking one step per step_out pulse.
 */
// Function
// - Symmetric fixed move: acceleration past one twelfth of total turns ramp down.
// - Decelerating stop while accelerating first brings acceleration to zero.
// - Drive speed changes ignored during S-curve fixed-pulse moves.
// - Pulse count rewrite while decelerating is taken; shape then not exact.
// - Low initial speed may end early or creep at initial speed.
// - Surplus pulses from zero to initial speed come out at the peak.
// - Continuous S-curve speed changes only taken at constant speed.
// - Increase, decrease and sync speed changes invalid while ramping in S-curve mode.
// - Partial S-curve ramps acceleration to the setting then holds it.
// - Ramp down acceleration once speed gap falls below ramp-up gain.
// - Deceleration uses the same ramp, hold, ramp-down shape.
// - Mode bits: 0 manual decel, 1 separate decel, 2 S-curve.
// - Auto decel starts when remaining pulses drop to acceleration pulses.
`timescale 1ns/1ns
module scp_axis
    import scp_pkg::*;
#(
    parameter int TICKS = TICK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sync_speed_load,
    input  wire logic [31:0] sync_speed_value,
    output logic             step_out
);
    logic [2:0]  mode_config_reg;
    logic [31:0] jerk_param;
    logic [31:0] accel_param;
    logic [31:0] initial_speed_param;
    logic [31:0] drive_speed_param;
    logic [31:0] pulse_count_param;
    logic [31:0] speed_step;
    scp_state_e  state;
    logic [31:0] speed;
    logic [31:0] accel;
    logic [31:0] target;
    logic [31:0] gain_up;
    logic [31:0] gain_dn;
    logic [31:0] out_cnt;
    logic [31:0] acc_pulses;
    logic        fixed_move;
    logic        stop_pend;
    logic        reject_flag;
    logic        tick;
    logic        pulse;
    logic        wr_en;
    logic        rd_setup;
    logic        cmd_wr;
    logic        start_fixed;
    logic        start_cont;
    logic        manual_decel_sel;
    logic        separate_decel_sel;
    logic        scurve_sel;
    logic        ramping;
    logic        chg_ok;
    logic        chg_req;
    logic [31:0] chg_value;
    logic [31:0] ej;
    logic [31:0] floor_spd;
    logic [31:0] remaining;
    logic [32:0] acc_inc;
    logic [32:0] spd_up;
    logic [32:0] spd_dn_lim;
    logic [35:0] out_x12;
    logic        tri12;
    logic        gap_small;
    logic        dec_close;
    logic        last_pulse;
    logic        constant_speed_flag;
    logic [31:0] rd_mux;
    logic        rd_map;

    scp_tick_gen #(
        .TICKS   (TICKS)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    scp_pulse_gen #(
        .DEN     (PULSE_DEN)
    ) u_pulse (
        .pclk    (pclk),
        .presetn (presetn),
        .en      (state != ST_IDLE),
        .speed   (speed),
        .pulse   (pulse)
    );

    assign step_out = pulse;

    // APB decode: one wait state, access completes when pready is seen high
    assign wr_en    = psel && penable && pready && pwrite;
    assign rd_setup = psel && penable && !pready;
    assign cmd_wr   = wr_en && (paddr == OFF_COMMAND);

    assign manual_decel_sel   = mode_config_reg[MODE_MANUAL_BIT];
    assign separate_decel_sel = mode_config_reg[MODE_SEPDEC_BIT];
    assign scurve_sel         = mode_config_reg[MODE_SCURVE_BIT];

    assign start_fixed = cmd_wr && (pwdata[7:0] == CMD_START_FIXED) && (pulse_count_param != ZERO_WORD);
    assign start_cont  = cmd_wr && (pwdata[7:0] == CMD_START_CONT);

    // Linear mode: acceleration steps straight to its setting
    assign ej = scurve_sel ? jerk_param : accel_param;

    assign ramping             = (state != ST_IDLE) && (state != ST_CONST) && (state != ST_CREEP);
    assign constant_speed_flag = (state == ST_CONST);

    // Speed change gate for writes, increase/decrease and sync loads
    always_comb begin
        chg_req   = 1'b0;
        chg_value = target;
        if (wr_en && (paddr == OFF_DRIVE_SPEED)) begin
            chg_req   = 1'b1;
            chg_value = pwdata;
        end else if (cmd_wr && (pwdata[7:0] == CMD_SPEED_INC)) begin
            chg_req   = 1'b1;
            chg_value = target + speed_step;
        end else if (cmd_wr && (pwdata[7:0] == CMD_SPEED_DEC)) begin
            chg_req   = 1'b1;
            chg_value = (target > speed_step) ? target - speed_step : initial_speed_param;
        end else if (sync_speed_load) begin
            chg_req   = 1'b1;
            chg_value = sync_speed_value;
        end
    end

    always_comb begin
        if (state == ST_IDLE || !scurve_sel) begin
            chg_ok = 1'b1;
        end else if (fixed_move) begin
            chg_ok = 1'b0;
        end else begin
            chg_ok = constant_speed_flag && !ramping;
        end
    end

    assign floor_spd  = (stop_pend || fixed_move) ? initial_speed_param : target;
    assign remaining  = (pulse_count_param > out_cnt) ? pulse_count_param - out_cnt : ZERO_WORD;
    assign acc_inc    = {1'b0, accel} + {1'b0, ej};
    assign spd_up     = {1'b0, speed} + {1'b0, accel};
    assign spd_dn_lim = {1'b0, floor_spd} + {1'b0, accel};
    assign out_x12    = {1'b0, out_cnt, 3'b000} + {2'b00, out_cnt, 2'b00};
    assign tri12      = fixed_move && !manual_decel_sel && !separate_decel_sel
                        && (out_x12 > {4'h0, pulse_count_param});
    assign gap_small  = (target <= speed) || ((target - speed) <= gain_up);
    assign dec_close  = (speed <= floor_spd) || ((speed - floor_spd) <= gain_dn);
    assign last_pulse = fixed_move && pulse && ((out_cnt + 32'h1) >= pulse_count_param);

    // Register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_config_reg     <= MODE_RESET;
            jerk_param          <= JERK_RESET;
            accel_param         <= ACCEL_MAX;
            initial_speed_param <= INIT_SPEED_RST;
            drive_speed_param   <= DRIVE_SPEED_RST;
            pulse_count_param   <= ZERO_WORD;
            speed_step          <= ZERO_WORD;
        end else if (wr_en) begin
            unique case (paddr)
                OFF_MODE:        mode_config_reg     <= pwdata[2:0];
                OFF_JERK:        jerk_param          <= pwdata;
                OFF_ACCEL:       accel_param         <= pwdata;
                OFF_INIT_SPEED:  initial_speed_param <= pwdata;
                OFF_DRIVE_SPEED: drive_speed_param   <= pwdata;
                // Taken at once even mid-deceleration; the curve then bends
                OFF_PULSE_COUNT: pulse_count_param   <= pwdata;
                OFF_SPEED_STEP:  speed_step          <= pwdata;
                default: begin
                end
            endcase
        end
    end

    // Pulse counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_cnt    <= ZERO_WORD;
            acc_pulses <= ZERO_WORD;
        end else if (state == ST_IDLE) begin
            if (start_fixed || start_cont) begin
                out_cnt    <= ZERO_WORD;
                acc_pulses <= ZERO_WORD;
            end
        end else if (pulse) begin
            out_cnt <= out_cnt + 32'h1;
            if (state == ST_ACC_UP || state == ST_ACC_HOLD || state == ST_ACC_DOWN) begin
                acc_pulses <= acc_pulses + 32'h1;
            end
        end
    end

    // Rejected speed change seen; cleared by a status read, a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reject_flag <= 1'b0;
        end else if (chg_req && !chg_ok) begin
            reject_flag <= 1'b1;
        end else if (psel && penable && pready && !pwrite && paddr == OFF_STATUS) begin
            reject_flag <= 1'b0;
        end
    end

    // Profile engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_IDLE;
            speed      <= ZERO_WORD;
            accel      <= ZERO_WORD;
            target     <= ZERO_WORD;
            gain_up    <= ZERO_WORD;
            gain_dn    <= ZERO_WORD;
            fixed_move <= 1'b0;
            stop_pend  <= 1'b0;
        end else if (state == ST_IDLE) begin
            if (start_fixed || start_cont) begin
                fixed_move <= start_fixed;
                stop_pend  <= 1'b0;
                target     <= drive_speed_param;
                speed      <= initial_speed_param;
                accel      <= ZERO_WORD;
                gain_up    <= ZERO_WORD;
                gain_dn    <= ZERO_WORD;
                state      <= (drive_speed_param > initial_speed_param) ? ST_ACC_UP : ST_CONST;
            end
        end else if (last_pulse) begin
            // Count done ends the move wherever the speed stands
            state <= ST_IDLE;
            accel <= ZERO_WORD;
        end else begin
            if (cmd_wr && pwdata[7:0] == CMD_DECEL_STOP) begin
                stop_pend <= 1'b1;
            end
            if (chg_req && chg_ok) begin
                target <= chg_value;
            end
            // A rejected request leaves target alone and is not kept
            if (tick) begin
                unique case (state)
                    ST_ACC_UP: begin
                        speed <= (spd_up >= {1'b0, target}) ? target : spd_up[31:0];
                        if (stop_pend || tri12 || gap_small) begin
                            state <= ST_ACC_DOWN;
                        end else if (acc_inc >= {1'b0, accel_param}) begin
                            accel   <= accel_param;
                            gain_up <= gain_up + accel;
                            state   <= ST_ACC_HOLD;
                        end else begin
                            accel   <= acc_inc[31:0];
                            gain_up <= gain_up + accel;
                        end
                    end
                    ST_ACC_HOLD: begin
                        speed <= (spd_up >= {1'b0, target}) ? target : spd_up[31:0];
                        if (stop_pend || gap_small) begin
                            state <= ST_ACC_DOWN;
                        end
                    end
                    ST_ACC_DOWN: begin
                        speed <= (spd_up >= {1'b0, target}) ? target : spd_up[31:0];
                        if (accel <= ej || spd_up >= {1'b0, target}) begin
                            accel   <= ZERO_WORD;
                            gain_dn <= ZERO_WORD;
                            // Deceleration only once acceleration is gone
                            state   <= stop_pend ? ST_DEC_UP : ST_CONST;
                        end else begin
                            accel <= accel - ej;
                        end
                    end
                    ST_CONST: begin
                        // Pulses left over from the short ramp run here at the peak
                        if (stop_pend || (fixed_move && !manual_decel_sel
                                          && remaining <= acc_pulses)) begin
                            gain_dn <= ZERO_WORD;
                            state   <= ST_DEC_UP;
                        end else if (target > speed) begin
                            gain_up <= ZERO_WORD;
                            state   <= ST_ACC_UP;
                        end else if (target < speed) begin
                            gain_dn <= ZERO_WORD;
                            state   <= ST_DEC_UP;
                        end
                    end
                    ST_DEC_UP: begin
                        speed <= ({1'b0, speed} <= spd_dn_lim) ? floor_spd : speed - accel;
                        if (dec_close) begin
                            state <= ST_DEC_DOWN;
                        end else if (acc_inc >= {1'b0, accel_param}) begin
                            accel   <= accel_param;
                            gain_dn <= gain_dn + accel;
                            state   <= ST_DEC_HOLD;
                        end else begin
                            accel   <= acc_inc[31:0];
                            gain_dn <= gain_dn + accel;
                        end
                    end
                    ST_DEC_HOLD: begin
                        speed <= ({1'b0, speed} <= spd_dn_lim) ? floor_spd : speed - accel;
                        if (dec_close) begin
                            state <= ST_DEC_DOWN;
                        end
                    end
                    ST_DEC_DOWN: begin
                        if (accel <= ej || {1'b0, speed} <= spd_dn_lim) begin
                            speed <= floor_spd;
                            accel <= ZERO_WORD;
                            if (fixed_move) begin
                                state <= ST_CREEP;
                            end else if (stop_pend) begin
                                state <= ST_IDLE;
                            end else begin
                                state <= ST_CONST;
                            end
                        end else begin
                            speed <= speed - accel;
                            accel <= accel - ej;
                        end
                    end
                    ST_CREEP: begin
                        // Leftover pulses go out at initial speed until the count ends
                        speed <= initial_speed_param;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Read side
    always_comb begin
        rd_map = 1'b1;
        rd_mux = ZERO_WORD;
        unique case (paddr)
            OFF_MODE:        rd_mux = {29'h0, mode_config_reg};
            OFF_JERK:        rd_mux = jerk_param;
            OFF_ACCEL:       rd_mux = accel_param;
            OFF_INIT_SPEED:  rd_mux = initial_speed_param;
            OFF_DRIVE_SPEED: rd_mux = drive_speed_param;
            OFF_PULSE_COUNT: rd_mux = pulse_count_param;
            OFF_SPEED_STEP:  rd_mux = speed_step;
            OFF_COMMAND:     rd_mux = ZERO_WORD;
            OFF_STATUS: begin
                rd_mux[ST_BUSY_BIT]   = (state != ST_IDLE);
                rd_mux[ST_ACCEL_BIT]  = (state == ST_ACC_UP) || (state == ST_ACC_HOLD) || (state == ST_ACC_DOWN);
                rd_mux[ST_CONST_BIT]  = constant_speed_flag;
                rd_mux[ST_DECEL_BIT]  = (state == ST_DEC_UP) || (state == ST_DEC_HOLD) || (state == ST_DEC_DOWN);
                rd_mux[ST_REJECT_BIT] = reject_flag;
            end
            OFF_CUR_SPEED:   rd_mux = speed;
            OFF_OUT_COUNT:   rd_mux = out_cnt;
            OFF_CUR_ACCEL:   rd_mux = accel;
            default:         rd_map = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= ZERO_WORD;
        end else if (rd_setup) begin
            pready  <= 1'b1;
            pslverr <= !rd_map;
            prdata  <= (pwrite || !rd_map) ? ZERO_WORD : rd_mux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule

// File: hw/scp_pkg.sv
/*
 * Shared constants of the S-curve profile block: register offsets, mode and
 * status bit positions, command codes, reset values, timing counts and the
 * profile state type.
 * Assumes a 125 MHz pclk; speeds are in pulses per second, acceleration in
 * speed units per profile tick and jerk in acceleration units per tick.
 */
package scp_pkg;

    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          TICK_PERIOD_NS  = 1000;
    // Least time, so round up to whole cycles
    localparam int          TICK_CYCLES     = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // One pulse per second of speed: the phase wraps at the clock rate
    localparam logic [31:0] PULSE_DEN       = 32'(1000000000 / CLK_PERIOD_NS);

    localparam logic [7:0]  OFF_MODE        = 8'h00;
    localparam logic [7:0]  OFF_JERK        = 8'h04;
    localparam logic [7:0]  OFF_ACCEL       = 8'h08;
    localparam logic [7:0]  OFF_INIT_SPEED  = 8'h0C;
    localparam logic [7:0]  OFF_DRIVE_SPEED = 8'h10;
    localparam logic [7:0]  OFF_PULSE_COUNT = 8'h14;
    localparam logic [7:0]  OFF_SPEED_STEP  = 8'h18;
    localparam logic [7:0]  OFF_COMMAND     = 8'h1C;
    localparam logic [7:0]  OFF_STATUS      = 8'h20;
    localparam logic [7:0]  OFF_CUR_SPEED   = 8'h24;
    localparam logic [7:0]  OFF_OUT_COUNT   = 8'h28;
    localparam logic [7:0]  OFF_CUR_ACCEL   = 8'h2C;

    localparam int          MODE_MANUAL_BIT = 0;
    localparam int          MODE_SEPDEC_BIT = 1;
    localparam int          MODE_SCURVE_BIT = 2;

    localparam int          ST_BUSY_BIT     = 0;
    localparam int          ST_ACCEL_BIT    = 1;
    localparam int          ST_CONST_BIT    = 2;
    localparam int          ST_DECEL_BIT    = 3;
    localparam int          ST_REJECT_BIT   = 4;

    localparam logic [7:0]  CMD_START_FIXED = 8'h20;
    localparam logic [7:0]  CMD_START_CONT  = 8'h22;
    localparam logic [7:0]  CMD_DECEL_STOP  = 8'h26;
    localparam logic [7:0]  CMD_SPEED_INC   = 8'h70;
    localparam logic [7:0]  CMD_SPEED_DEC   = 8'h71;

    localparam logic [2:0]  MODE_RESET      = 3'h0;
    localparam logic [31:0] JERK_RESET      = 32'h00000001;
    localparam logic [31:0] ACCEL_MAX       = 32'h1FFFFFFF;
    localparam logic [31:0] INIT_SPEED_RST  = 32'h00000001;
    localparam logic [31:0] DRIVE_SPEED_RST = 32'h00000001;
    localparam logic [31:0] ZERO_WORD       = 32'h00000000;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ACC_UP, ST_ACC_HOLD, ST_ACC_DOWN, ST_CONST,
        ST_DEC_UP, ST_DEC_HOLD, ST_DEC_DOWN, ST_CREEP
    } scp_state_e;

endpackage

// File: hw/scp_pulse_gen.sv
/*
 * Step pulse generator: phase accumulator adds the speed every cycle and
 * emits a one-cycle pulse on each wrap at DEN.
 * Assumes speed stays at most DEN/2, so pulses are at least two cycles apart.
 */
`timescale 1ns/1ns
module scp_pulse_gen
    import scp_pkg::*;
#(
    parameter logic [31:0] DEN = PULSE_DEN
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        en,
    input  wire logic [31:0] speed,
    output logic             pulse
);
    logic [32:0] phase;
    logic [32:0] next_phase;

    assign next_phase = phase + {1'b0, speed};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= '0;
            pulse <= 1'b0;
        end else if (!en) begin
            // Fresh phase per move keeps the first pulse timing repeatable
            phase <= '0;
            pulse <= 1'b0;
        end else if (next_phase >= {1'b0, DEN}) begin
            phase <= next_phase - {1'b0, DEN};
            pulse <= 1'b1;
        end else begin
            phase <= next_phase;
            pulse <= 1'b0;
        end
    end

endmodule

// File: hw/scp_tick_gen.sv
/*
 * Profile time base: one-cycle tick every TICKS clock cycles.
 * Assumes pclk free running and presetn asynchronous, active low.
 */
`timescale 1ns/1ns
module scp_tick_gen
    import scp_pkg::*;
#(
    parameter int TICKS = TICK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    localparam int CW = $clog2(TICKS + 1);

    logic [CW-1:0] cnt;

    // A single-cycle period would leave tick stuck high
    if (TICKS < 2) begin : g_bad_ticks
        $error("scp_tick_gen: TICKS must be at least 2");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (cnt == CW'(TICKS - 1)) begin
            cnt  <= '0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule

// File: test/scp_axis_assertions.sv
/* Port checker for scp_axis: APB timing, error response, status and step pulses.
   Assumes it is bound to the top module ports on one clock. */
`timescale 1ns/1ns
module scp_axis_chk
    import scp_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        step_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("pready not one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    chk_ready_qual: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    chk_err_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > OFF_CUR_ACCEL))
        else $error("pslverr wrong for address");
    chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("data on error");
    chk_mode_bits: assert property (pready && !pwrite && paddr == OFF_MODE |-> prdata[31:3] == 29'h0)
        else $error("mode spare bits set");
    chk_state_excl: assert property (pready && !pwrite && paddr == OFF_STATUS |-> $countones(prdata[3:1]) <= 1)
        else $error("two ramp states");
    chk_step_gap: assert property (step_out |=> !step_out)
        else $error("step too long");
    chk_quiet_start: assert property ($rose(presetn) |-> !step_out && !pready)
        else $error("output after reset");
endmodule
bind scp_axis scp_axis_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .step_out(step_out));

// File: test/scp_axis_test.sv
/* Self-checking bench for scp_axis: registers, fixed and continuous S-curve moves.
   Assumes TICKS of 4 and the step sink as motor driver. */
`timescale 1ns/1ns
module scp_axis_test
    import scp_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, step_out, sld, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, sval, rd, v, np, s0;
    logic [31:0] steps;
    int          seed = 32'hbf13fc4c;
    int          miscompares = 0;
    int          cmp_count = 0;
    scp_axis #(.TICKS(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_speed_load(sld), .sync_speed_value(sval), .step_out(step_out));
    scp_step_sink i_sink (.pclk(pclk), .presetn(presetn), .step(step_out), .steps(steps));
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Mode readback keeps only the three mode bits
    function automatic logic [31:0] mode_rd(logic [31:0] w);
        return {29'h0, w[2:0]};
    endfunction
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Answer taken at the rising edge that samples pready high, released only after it
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 40) miscompares++;
        if (n == 40) wrap_up();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_st(int b, logic val);
        int n;
        for (n = 0; n < 4000; n++) begin
            apb(1'b0, OFF_STATUS, 32'h0);
            if (rd[b] === val) break;
        end
        if (n == 4000) miscompares++;
        if (n == 4000) wrap_up();
    endtask
    task automatic sync_pulse();
        @(posedge pclk);
        sld <= 1'b1;
        sval <= 32'h00800000 | 32'($random(seed) & 32'hFFFFF);
        @(posedge pclk);
        sld <= 1'b0;
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        static logic [7:0]  offs [5] = '{OFF_MODE, OFF_JERK, OFF_ACCEL, OFF_INIT_SPEED, OFF_DRIVE_SPEED};
        static logic [31:0] rvals [5] = '{32'h0, JERK_RESET, ACCEL_MAX, INIT_SPEED_RST, DRIVE_SPEED_RST};
        // Full accel last, so the continuous moves ramp in a few hundred cycles
        static logic [31:0] acc [2] = '{32'h000000C8, ACCEL_MAX};
        {presetn, psel, penable, pwrite, sld, paddr, pwdata, sval} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0);
            check("reset value", rd, rvals[i]);
        end
        apb(1'b1, 8'hFC, 32'h5);
        check("unmapped error", {31'h0, er}, 32'h1);
        repeat (3) begin
            v = $random(seed);
            apb(1'b1, OFF_MODE, v);
            apb(1'b0, OFF_MODE, 32'h0);
            check("mode bits", rd, mode_rd(v));
        end
        apb(1'b1, OFF_MODE, 32'h4);
        apb(1'b1, OFF_JERK, 32'd900);
        apb(1'b1, OFF_INIT_SPEED, 32'd2000000);
        apb(1'b1, OFF_SPEED_STEP, 32'd1000);
        // Full accel gives a pure S-curve, a small one a linear middle section
        foreach (acc[i]) begin
            apb(1'b1, OFF_ACCEL, acc[i]);
            apb(1'b1, OFF_DRIVE_SPEED, 32'd10000000);
            np = 32'd40 + 32'($random(seed) & 63);
            apb(1'b1, OFF_PULSE_COUNT, np);
            s0 = steps;
            apb(1'b1, OFF_COMMAND, {24'h0, CMD_START_FIXED});
            apb(1'b1, OFF_DRIVE_SPEED, 32'd20000000);
            apb(1'b1, OFF_COMMAND, {24'h0, CMD_SPEED_INC});
            apb(1'b0, OFF_STATUS, 32'h0);
            check("fixed reject", {31'h0, rd[ST_REJECT_BIT]}, 32'h1);
            apb(1'b0, OFF_STATUS, 32'h0);
            check("reject cleared", {31'h0, rd[ST_REJECT_BIT]}, 32'h0);
            wait_st(ST_BUSY_BIT, 1'b0);
            check("step total", steps - s0, np);
            apb(1'b0, OFF_OUT_COUNT, 32'h0);
            check("out count", rd, np);
        end
        apb(1'b1, OFF_DRIVE_SPEED, 32'd4000000);
        apb(1'b1, OFF_COMMAND, {24'h0, CMD_START_CONT});
        apb(1'b1, OFF_COMMAND, {24'h0, CMD_SPEED_DEC});
        apb(1'b0, OFF_STATUS, 32'h0);
        check("ramp reject", {31'h0, rd[ST_REJECT_BIT]}, 32'h1);
        wait_st(ST_CONST_BIT, 1'b1);
        apb(1'b1, OFF_COMMAND, {24'h0, CMD_SPEED_INC});
        apb(1'b0, OFF_STATUS, 32'h0);
        check("const accept", {31'h0, rd[ST_REJECT_BIT]}, 32'h0);
        apb(1'b1, OFF_COMMAND, {24'h0, CMD_DECEL_STOP});
        wait_st(ST_BUSY_BIT, 1'b0);
        apb(1'b1, OFF_DRIVE_SPEED, 32'd10000000);
        apb(1'b1, OFF_COMMAND, {24'h0, CMD_START_CONT});
        repeat (100) @(posedge pclk);
        sync_pulse();
        apb(1'b1, OFF_COMMAND, {24'h0, CMD_DECEL_STOP});
        apb(1'b0, OFF_STATUS, 32'h0);
        check("stop keeps ramp", {28'h0, rd[4:1]}, 32'h9);
        wait_st(ST_BUSY_BIT, 1'b0);
        wrap_up();
    end
endmodule

// File: test/scp_step_sink.sv
/* Motor driver stand-in: counts step pulses.
   Assumes one step for each high pclk cycle of step. */
`timescale 1ns/1ns
module scp_step_sink (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        step,
    output logic      [31:0] steps
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) steps <= 32'h0;
        else if (step) steps <= steps + 32'h1;
    end
endmodule
